// [core/fsas_ctrl.sv]
// Flash host controller: Avalon-MM registers and command sequencer.
`timescale 1ns/10ps
`include "fsas_map.svh"
module fsas_ctrl #(
  parameter int P_ACC_CYC  = `FSAS_ACC_CYC,
  parameter int P_WP_CYC   = `FSAS_WP_CYC,
  parameter int P_HOLD_CYC = `FSAS_HOLD_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n,
  output logic [18:0]      o_addr,
  output logic [7:0]       o_dq_out,
  output logic             o_dq_oe_n,
  input  wire logic [7:0]  i_dq_in,
  input  wire logic        i_ready_busy_out
);
  import fsas_pkg::*;

  typedef struct packed {
    fsas_mst_t   st;
    fsas_op_t    op;
    logic [2:0]  idx;
    logic [18:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  prev;
    logic        busy;
    logic        err;
    logic        tog_one;
    logic        tog_two;
    logic        timeout;
    logic        poll;
    logic        etimer;
    logic        rb_meta;
    logic        rb_sync;
    logic        waitreq;
    logic [31:0] readdata;
    logic        cyc_start;
    logic        cyc_we;
    logic [18:0] cyc_addr;
    logic [7:0]  cyc_data;
  } fsas_ctl_t;

  fsas_ctl_t   q;
  fsas_ctl_t   next_q;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  fsas_step_t  step;

  // ========================================================================
  // Sequence helpers.
  function automatic fsas_step_t mk(input logic last, input logic rd,
                                    input logic [18:0] a, input logic [7:0] d);
    fsas_step_t s;
    s.last = last;
    s.rd   = rd;
    s.addr = a;
    s.data = d;
    return s;
  endfunction

  // Two unlock writes open every multi-cycle command except the poll, which is two plain reads.
  function automatic fsas_step_t unlock(input logic second);
    return second ? mk(1'b0, 1'b0, `FSAS_UNLOCK_A2, `FSAS_UNLOCK_D2)
                  : mk(1'b0, 1'b0, `FSAS_UNLOCK_A1, `FSAS_UNLOCK_D1);
  endfunction

  function automatic fsas_step_t seq_get(input fsas_op_t op, input logic [2:0] i,
                                         input logic [18:0] a, input logic [7:0] d);
    fsas_step_t s;
    s = mk(1'b1, 1'b1, a, 8'h00);
    case (op)
      FSAS_OP_READ:    s = mk(1'b1, 1'b1, a, 8'h00);
      FSAS_OP_WRITE:   s = mk(1'b1, 1'b0, a, d);
      FSAS_OP_PROGRAM: begin
        if (i < 3'h2) begin
          s = unlock(i[0]);
        end else if (i == 3'h2) begin
          s = mk(1'b0, 1'b0, `FSAS_UNLOCK_A1, `FSAS_CMD_PROGRAM);
        end else begin
          s = mk(1'b1, 1'b0, a, d);
        end
      end
      FSAS_OP_ERASE: begin
        if (i == 3'h0 || i == 3'h3) begin
          s = unlock(1'b0);
        end else if (i == 3'h1 || i == 3'h4) begin
          s = unlock(1'b1);
        end else if (i == 3'h2) begin
          s = mk(1'b0, 1'b0, `FSAS_UNLOCK_A1, `FSAS_CMD_ERASE);
        end else begin
          s = mk(1'b1, 1'b0, a, `FSAS_CMD_SECTOR);
        end
      end
      // Address is don't-care, so the current address register is reused.
      FSAS_OP_SUSPEND: s = mk(1'b1, 1'b0, a, `FSAS_CMD_SUSPEND);
      FSAS_OP_RESUME:  s = mk(1'b1, 1'b0, a, `FSAS_CMD_RESUME);
      FSAS_OP_AUTOSEL: begin
        if (i < 3'h2) begin
          s = unlock(i[0]);
        end else begin
          s = mk(1'b1, 1'b0, `FSAS_UNLOCK_A1, `FSAS_CMD_AUTOSEL);
        end
      end
      // One way out of auto-select back to array reads; a raw write of F0 also works.
      FSAS_OP_RESET:   s = mk(1'b1, 1'b0, a, `FSAS_CMD_RESET);
      // Two back-to-back reads at the software address.
      FSAS_OP_POLL:    s = mk(i != 3'h0, 1'b1, a, 8'h00);
      default:         s = mk(1'b1, 1'b1, a, 8'h00);
    endcase
    return s;
  endfunction

  function automatic logic op_valid(input logic [3:0] v);
    return v <= FSAS_OP_POLL;
  endfunction

  // Byte-lane merge of an Avalon write into a stored word.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_read(input logic [2:0] w, input fsas_ctl_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (w)
      `FSAS_REG_CMD:   r = {28'h0000000, s.op};
      `FSAS_REG_ADDR:  r = {13'h0000, s.addr};
      `FSAS_REG_WDATA: r = {24'h000000, s.wdata};
      `FSAS_REG_STATUS: begin
        r[`FSAS_ST_BUSY]    = s.busy;
        r[`FSAS_ST_ERR]     = s.err;
        r[`FSAS_ST_TOG_ONE] = s.tog_one;
        r[`FSAS_ST_TOG_TWO] = s.tog_two;
        r[`FSAS_ST_TIMEOUT] = s.timeout;
        r[`FSAS_ST_POLL]    = s.poll;
        r[`FSAS_ST_ETIMER]  = s.etimer;
        r[`FSAS_ST_RDY]     = s.rb_sync;
      end
      `FSAS_REG_RDATA: r = {24'h000000, s.rdata};
      default:         r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign step = seq_get(q.op, q.idx, q.addr, q.wdata);

  // ========================================================================
  // Bus slave, sequencer and status decoding in one next-state process.
  always_comb begin
    logic [31:0] m;
    m                = 32'h0000_0000;
    next_q           = q;
    next_q.cyc_start = 1'b0;
    // Ready/busy is an open-drain pin from another domain, so it is synced.
    next_q.rb_meta   = i_ready_busy_out;
    next_q.rb_sync   = q.rb_meta;

    // Avalon: one wait cycle, then the answer with waitrequest low.
    if (q.waitreq) begin
      if (i_read || i_write) begin
        next_q.waitreq  = 1'b0;
        next_q.readdata = reg_read(i_address[4:2], q);
      end
    end else begin
      next_q.waitreq = 1'b1;
      if (i_write) begin
        case (i_address[4:2])
          `FSAS_REG_ADDR: begin
            m           = be_merge({13'h0000, q.addr}, i_writedata, i_byteenable);
            next_q.addr = m[18:0];
          end
          `FSAS_REG_WDATA: begin
            if (i_byteenable[0]) begin
              next_q.wdata = i_writedata[7:0];
            end
          end
          `FSAS_REG_CMD: begin
            // A command while busy or an unknown code is refused and flagged.
            if (i_byteenable[0]) begin
              if (q.busy || !op_valid(i_writedata[3:0])) begin
                next_q.err = 1'b1;
              end else begin
                next_q.err  = 1'b0;
                next_q.busy = 1'b1;
                next_q.op   = fsas_op_t'(i_writedata[3:0]);
                next_q.idx  = 3'h0;
                next_q.st   = FSAS_M_ISSUE;
              end
            end
          end
          default: begin
            next_q.err = q.err;
          end
        endcase
      end
    end

    case (q.st)
      FSAS_M_IDLE: begin
        next_q.busy = next_q.busy;
      end
      FSAS_M_ISSUE: begin
        next_q.cyc_start = 1'b1;
        next_q.cyc_we    = ~step.rd;
        next_q.cyc_addr  = step.addr;
        next_q.cyc_data  = step.data;
        next_q.st        = FSAS_M_WAIT;
      end
      FSAS_M_WAIT: begin
        if (cyc_done) begin
          if (step.rd) begin
            next_q.prev  = q.rdata;
            next_q.rdata = cyc_rdata;
          end
          if (step.last) begin
            next_q.st = FSAS_M_DONE;
          end else begin
            next_q.idx = q.idx + 3'h1;
            next_q.st  = FSAS_M_ISSUE;
          end
        end
      end
      FSAS_M_DONE: begin
        if (q.op == FSAS_OP_POLL) begin
          // Toggle bits are judged by comparing two successive reads.
          next_q.tog_one = q.prev[`FSAS_DQ_TOG_ONE] ^ q.rdata[`FSAS_DQ_TOG_ONE];
          next_q.tog_two = q.prev[`FSAS_DQ_TOG_TWO] ^ q.rdata[`FSAS_DQ_TOG_TWO];
          // Remaining flags come from the later read only, since bit 7 may
          // settle apart from the others on the first one.
          next_q.timeout = q.rdata[`FSAS_DQ_TIMEOUT];
          next_q.poll    = q.rdata[`FSAS_DQ_POLL];
          next_q.etimer  = q.rdata[`FSAS_DQ_ETIMER];
        end
        next_q.busy = 1'b0;
        next_q.st   = FSAS_M_IDLE;
      end
      default: begin
        next_q.st = FSAS_M_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register; waitrequest idles high so no request passes unseen.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q         <= '0;
      q.st      <= FSAS_M_IDLE;
      q.op      <= FSAS_OP_READ;
      q.rb_meta <= 1'b1;
      q.rb_sync <= 1'b1;
      q.waitreq <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign o_readdata    = q.readdata;
  assign o_waitrequest = q.waitreq;

  // ========================================================================
  // Pin-level cycle engine.
  fsas_bus_cycle #(
    .P_ACC_CYC  (P_ACC_CYC),
    .P_WP_CYC   (P_WP_CYC),
    .P_HOLD_CYC (P_HOLD_CYC)
  ) u_cyc (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_start   (q.cyc_start),
    .i_write   (q.cyc_we),
    .i_addr    (q.cyc_addr),
    .i_wdata   (q.cyc_data),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_ce_n    (o_ce_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe_n (o_dq_oe_n),
    .i_dq_in   (i_dq_in)
  );

endmodule

// [core/fsas_map.svh]
// Register offsets, flash command codes and timing constants of the flash host controller.
`ifndef FSAS_MAP_SVH
`define FSAS_MAP_SVH

// ==========================================================================
// Avalon-MM register word indices (address bits 4:2)
`define FSAS_REG_CMD      3'h0
`define FSAS_REG_ADDR     3'h1
`define FSAS_REG_WDATA    3'h2
`define FSAS_REG_STATUS   3'h3
`define FSAS_REG_RDATA    3'h4

// ==========================================================================
// Status register field positions
`define FSAS_ST_BUSY      0
`define FSAS_ST_ERR       1
`define FSAS_ST_TOG_ONE   2
`define FSAS_ST_TOG_TWO   3
`define FSAS_ST_TIMEOUT   4
`define FSAS_ST_POLL      5
`define FSAS_ST_ETIMER    6
`define FSAS_ST_RDY       7

// ==========================================================================
// Flash status byte bit positions
`define FSAS_DQ_POLL      7
`define FSAS_DQ_TOG_ONE   6
`define FSAS_DQ_TIMEOUT   5
`define FSAS_DQ_ETIMER    3
`define FSAS_DQ_TOG_TWO   2

// ==========================================================================
// Flash command cycles
`define FSAS_UNLOCK_A1    19'h00555
`define FSAS_UNLOCK_A2    19'h002aa
`define FSAS_UNLOCK_D1    8'haa
`define FSAS_UNLOCK_D2    8'h55
`define FSAS_CMD_PROGRAM  8'ha0
`define FSAS_CMD_ERASE    8'h80
`define FSAS_CMD_SECTOR   8'h30
`define FSAS_CMD_AUTOSEL  8'h90
`define FSAS_CMD_SUSPEND  8'hb0
`define FSAS_CMD_RESUME   8'h30
`define FSAS_CMD_RESET    8'hf0

// ==========================================================================
// Timing in nanoseconds and derived cycle counts at the 40 ns clock
`define FSAS_CLK_NS       40
`define FSAS_T_ACC_NS     90
`define FSAS_T_WP_NS      50
`define FSAS_T_HOLD_NS    40
`define FSAS_ACC_CYC      ((`FSAS_T_ACC_NS + `FSAS_CLK_NS - 1) / `FSAS_CLK_NS)
`define FSAS_WP_CYC       ((`FSAS_T_WP_NS + `FSAS_CLK_NS - 1) / `FSAS_CLK_NS)
`define FSAS_HOLD_CYC     ((`FSAS_T_HOLD_NS + `FSAS_CLK_NS - 1) / `FSAS_CLK_NS)

`endif

// [core/fsas_pkg.sv]
// Types shared by the flash host controller modules.
package fsas_pkg;

  // ========================================================================
  // Operations that software may start through the command register.
  typedef enum logic [3:0] {
    FSAS_OP_READ     = 4'h0,
    FSAS_OP_WRITE    = 4'h1,
    FSAS_OP_PROGRAM  = 4'h2,
    FSAS_OP_ERASE    = 4'h3,
    FSAS_OP_SUSPEND  = 4'h4,
    FSAS_OP_RESUME   = 4'h5,
    FSAS_OP_AUTOSEL  = 4'h6,
    FSAS_OP_RESET    = 4'h7,
    FSAS_OP_POLL     = 4'h8
  } fsas_op_t;

  // ========================================================================
  // Sequencer states, Gray coded along idle, issue, wait, done.
  typedef enum logic [1:0] {
    FSAS_M_IDLE  = 2'h0,
    FSAS_M_ISSUE = 2'h1,
    FSAS_M_WAIT  = 2'h3,
    FSAS_M_DONE  = 2'h2
  } fsas_mst_t;

  // ========================================================================
  // Bus cycle states, Gray coded along idle, setup, strobe, hold.
  typedef enum logic [1:0] {
    FSAS_C_IDLE   = 2'h0,
    FSAS_C_SETUP  = 2'h1,
    FSAS_C_STROBE = 2'h3,
    FSAS_C_HOLD   = 2'h2
  } fsas_cst_t;

  // ========================================================================
  // One step of a command sequence.
  typedef struct packed {
    logic        last;
    logic        rd;
    logic [18:0] addr;
    logic [7:0]  data;
  } fsas_step_t;

endpackage

// [core/fsas_bus_cycle.sv]
// One asynchronous flash read or write cycle on the chip pins.
`timescale 1ns/10ps
`include "fsas_map.svh"
module fsas_bus_cycle #(
  parameter int P_ACC_CYC  = `FSAS_ACC_CYC,
  parameter int P_WP_CYC   = `FSAS_WP_CYC,
  parameter int P_HOLD_CYC = `FSAS_HOLD_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic [18:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n,
  output logic [18:0]      o_addr,
  output logic [7:0]       o_dq_out,
  output logic             o_dq_oe_n,
  input  wire logic [7:0]  i_dq_in
);
  import fsas_pkg::*;

  // ========================================================================
  // Elaboration check: the 4-bit counter holds the read strobe plus sync.
  if (P_ACC_CYC < 1 || P_ACC_CYC > 12 || P_WP_CYC < 1 || P_WP_CYC > 15 ||
      P_HOLD_CYC < 1 || P_HOLD_CYC > 15) begin : g_chk
    $error("fsas_bus_cycle: timing counts out of range");
  end

  localparam logic [3:0] RD_CYC = 4'(P_ACC_CYC + 2);
  localparam logic [3:0] WP_CYC = 4'(P_WP_CYC);
  localparam logic [3:0] HD_CYC = 4'(P_HOLD_CYC);

  typedef struct packed {
    fsas_cst_t   st;
    logic [3:0]  cnt;
    logic        wr;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [18:0] addr;
    logic [7:0]  dq;
    logic        dq_oe_n;
    logic [7:0]  dq_meta;
    logic [7:0]  dq_sync;
    logic [7:0]  rdata;
    logic        done;
  } fsas_cyc_t;

  fsas_cyc_t q;
  fsas_cyc_t next_q;

  // ========================================================================
  // Cycle sequencing. The read strobe is stretched by two cycles because the
  // data lines pass a two-stage synchroniser before they are captured.
  always_comb begin
    next_q         = q;
    next_q.done    = 1'b0;
    next_q.dq_meta = i_dq_in;
    next_q.dq_sync = q.dq_meta;
    case (q.st)
      FSAS_C_IDLE: begin
        if (i_start) begin
          next_q.st      = FSAS_C_SETUP;
          next_q.wr      = i_write;
          next_q.addr    = i_addr;
          next_q.dq      = i_wdata;
          next_q.ce_n    = 1'b0;
          next_q.dq_oe_n = ~i_write;
        end
      end
      FSAS_C_SETUP: begin
        next_q.st   = FSAS_C_STROBE;
        next_q.cnt  = q.wr ? WP_CYC : RD_CYC;
        next_q.we_n = ~q.wr;
        next_q.oe_n = q.wr;
      end
      FSAS_C_STROBE: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          // Rising write strobe latches the command; status is valid after it.
          next_q.st    = FSAS_C_HOLD;
          next_q.cnt   = HD_CYC;
          next_q.we_n  = 1'b1;
          next_q.oe_n  = 1'b1;
          next_q.rdata = q.wr ? q.rdata : q.dq_sync;
        end
      end
      FSAS_C_HOLD: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          next_q.st      = FSAS_C_IDLE;
          next_q.ce_n    = 1'b1;
          next_q.dq_oe_n = 1'b1;
          next_q.done    = 1'b1;
        end
      end
      default: begin
        next_q.st = FSAS_C_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register with synchronous reset to an idle, released bus.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q         <= '0;
      q.st      <= FSAS_C_IDLE;
      q.ce_n    <= 1'b1;
      q.we_n    <= 1'b1;
      q.oe_n    <= 1'b1;
      q.dq_oe_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign o_done    = q.done;
  assign o_rdata   = q.rdata;
  assign o_ce_n    = q.ce_n;
  assign o_we_n    = q.we_n;
  assign o_oe_n    = q.oe_n;
  assign o_addr    = q.addr;
  assign o_dq_out  = q.dq;
  assign o_dq_oe_n = q.dq_oe_n;

endmodule

// [sim/fsas_assertions.sv]
// Port checker of the flash host controller.
`timescale 1ns/10ps
module fsas_chk #(
  parameter int P_ACC_CYC = 3,
  parameter int P_WP_CYC  = 2
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic        o_waitrequest,
  input wire logic        o_ce_n,
  input wire logic        o_we_n,
  input wire logic        o_oe_n,
  input wire logic [18:0] o_addr,
  input wire logic [7:0]  o_dq_out,
  input wire logic        o_dq_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int wcnt;
  int rcnt;
  // ========
  // Strobe length counters, so a width slip in the cycle engine is caught.
  always_ff @(posedge i_clk) begin
    wcnt <= (i_rst || o_we_n) ? 0 : wcnt + 1;
    rcnt <= (i_rst || o_oe_n) ? 0 : rcnt + 1;
  end
  // ========
  // Pin and bus relations.
  wr_sel_a: assert property (!o_we_n |-> !o_ce_n && !o_dq_oe_n) else $error("we bad");
  rd_sel_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n) else $error("oe bad");
  rd_free_a: assert property (!o_oe_n |-> o_dq_oe_n) else $error("dq driven");
  wr_hold_a: assert property (!o_we_n && !$past(o_we_n) |->
    $stable(o_addr) && $stable(o_dq_out)) else $error("wr moved");
  wp_len_a: assert property ($rose(o_we_n) |-> wcnt == P_WP_CYC) else $error("we len");
  acc_len_a: assert property ($rose(o_oe_n) |-> rcnt == P_ACC_CYC + 2) else $error("oe len");
  ack_one_a: assert property ($fell(o_waitrequest) |=> o_waitrequest) else $error("ack len");
  ack_req_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no ack");
  idle_pin_a: assert property (o_ce_n |-> o_oe_n && o_we_n && o_dq_oe_n) else $error("idle");
  cover property ($fell(o_we_n));
  cover property ($fell(o_oe_n));
  cover property (i_read && !o_waitrequest);
endmodule

bind fsas_ctrl fsas_chk #(.P_ACC_CYC(P_ACC_CYC), .P_WP_CYC(P_WP_CYC)) i_fsas_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
  .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n));

// [sim/fsas_flash_model.sv]
// Behavioural model of the byte-wide flash device.
`timescale 1ns/10ps
module fsas_flash_model #(
  parameter logic [2:0] P_PROT  = 3'h7,
  parameter logic [7:0] P_MAKER = 8'h3c,
  parameter logic [7:0] P_DEV   = 8'hc3,
  parameter int         P_PG    = 50,
  parameter int         P_WIN   = 50,
  parameter int         P_ER    = 100,
  parameter int         P_SUS   = 5
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [18:0] i_addr,
  input  wire logic [7:0]  i_dq,
  output logic [7:0]       o_dq,
  output logic             o_dq_en,
  output logic             o_busy
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] rb = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [2:0] esec = 3'h0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic auto = 1'b0;
  int seq = 0;
  int es = 0;
  int pcnt = 0;
  int wcnt = 0;
  int ecnt = 0;
  int scnt = 0;
  // ========
  // Timers in 200 ns ticks; es is 0 idle, 1 window, 2 erasing, 3 suspended.
  always #200 begin
    if (pcnt > 0) pcnt--;
    if (es == 1) wcnt--;
    if (es == 1 && wcnt == 0) es = 2;
    if (es == 2) ecnt--;
    if (es == 2 && ecnt == 0) begin
      es = 0;
      foreach (mem[k]) if (k[18:16] == esec && esec != P_PROT) mem[k] = 8'hff;
    end
    if (scnt > 0) begin
      scnt--;
      if (scnt == 0 && es == 2) es = 3;
    end
  end
  // ========
  // Commands are taken at the end of the write strobe; a program in progress ignores them all.
  always @(posedge i_we_n) begin
    if (!i_ce_n && pcnt == 0) begin
      if (seq == 3) begin
        pd = i_dq;
        pcnt = (i_addr[18:16] == P_PROT) ? 5 : P_PG;
        if (i_addr[18:16] != P_PROT) mem[i_addr] = i_dq & (mem.exists(i_addr) ? mem[i_addr] : 8'hff);
        seq = 0;
      end else if (i_dq == 8'hf0) begin
        auto = 1'b0;
        seq = 0;
      end else if (i_dq == 8'hb0) begin
        if (es == 1) es = 3;
        if (es == 2) scnt = P_SUS;
      end else if (i_dq == 8'h30 && seq == 6) begin
        esec = i_addr[18:16];
        es = 1;
        wcnt = P_WIN;
        ecnt = (esec == P_PROT) ? 500 : P_ER;
        seq = 0;
      end else if (i_dq == 8'h30) begin
        if (es == 3) es = 2;
      end else if (i_dq == 8'haa) seq = (seq == 4) ? 5 : 1;
      else if (i_dq == 8'h55) seq = (seq == 5) ? 6 : 2;
      else if (i_dq == 8'h80 && seq == 2) seq = 4;
      else if (i_dq == 8'ha0 && seq == 2) seq = 3;
      else if (i_dq == 8'h90 && seq == 2) begin
        auto = 1'b1;
        seq = 0;
      end
    end
  end
  // ========
  // Each read strobe forms one byte from the present state.
  always @(negedge i_oe_n) begin
    if (!i_ce_n) begin
      if (auto && i_addr[7:0] == 8'h02) rb = {7'h0, i_addr[18:16] == P_PROT};
      else if (auto) rb = (i_addr[7:0] == 8'h01) ? P_DEV : P_MAKER;
      else if (pcnt > 0) begin
        t1 = ~t1;
        rb = {~pd[7], t1, 6'h00};
      end else if (es == 1 || es == 2) begin
        t1 = ~t1;
        t2 = t2 ^ (i_addr[18:16] == esec);
        rb = {1'b0, t1, 2'b00, es == 2, t2, 2'b00};
      end else if (es == 3 && i_addr[18:16] == esec) begin
        t2 = ~t2;
        rb = {1'b1, t1, 3'b000, t2, 2'b00};
      end else rb = mem.exists(i_addr) ? mem[i_addr] : 8'hff;
    end
  end
  // The pin drives only during a selected read.
  assign o_dq = rb;
  assign o_dq_en = !i_ce_n && !i_oe_n;
  assign o_busy = pcnt > 0 || es == 1 || es == 2;
endmodule

// [sim/fsas_ctrl_bench.sv]
// Self-checking bench of the flash host controller.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h seen %h", n, e, g); end end
module fsas_ctrl_bench;
  import fsas_pkg::*;
  localparam logic [2:0] P_PROT = 3'h7;
  localparam logic [7:0] P_MAKER = 8'h3c; // Arbitrary identity value.
  localparam logic [7:0] P_DEV = 8'hc3; // Arbitrary identity value.
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata, rd;
  logic o_waitrequest, o_ce_n, o_we_n, o_oe_n, o_dq_oe_n, m_en, m_busy;
  logic [18:0] o_addr, a, c;
  logic [7:0] o_dq_out, m_dq, dq, d, e;
  logic [18:0] adr_q[$];
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // The data wire has no pull, so a free bus shows a moving pattern.
  assign dq = !o_dq_oe_n ? o_dq_out : m_en ? m_dq : cyc[7:0] ^ 8'ha5;
  fsas_ctrl i_fsas_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_byteenable(4'hf), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .i_dq_in(dq),
    .i_ready_busy_out(!m_busy));
  fsas_flash_model #(.P_PROT(P_PROT), .P_MAKER(P_MAKER), .P_DEV(P_DEV)) i_fsas_flash_model (
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_addr(o_addr), .i_dq(dq),
    .o_dq(m_dq), .o_dq_en(m_en), .o_busy(m_busy));
  // ========
  // Clock and watchdog; the whole run needs well under the ceiling.
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    // Advanced by non-blocking assignment so the free-bus pattern never races the sampler.
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    i_address <= ad;
    i_writedata <= wd;
    i_write <= w;
    i_read <= !w;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask
  // Start one operation and wait for the sequencer to go idle.
  // Only the watchdog ends these waits, so a hang is always counted as a mismatch.
  task automatic op(input fsas_op_t cm, input logic [18:0] ad, input logic [7:0] wd);
    bus(1, 5'h04, {13'h0, ad});
    bus(1, 5'h08, {24'h0, wd});
    bus(1, 5'h00, {28'h0, cm});
    do bus(0, 5'h0c, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic wait_ready();
    do bus(0, 5'h0c, 0); while (rd[7] !== 1'b1);
  endtask
  task automatic rdb(input logic [18:0] ad);
    op(FSAS_OP_READ, ad, 0);
    bus(0, 5'h10, 0);
  endtask
  // ========
  // Main sequence.
  initial begin
    void'($urandom(32'h84e3));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    bus(0, 5'h0c, 0);
    `CHK("status", 8'h80, rd[7:0])
    bus(1, 5'h14, 32'h5a);
    bus(0, 5'h14, 0);
    `CHK("unmapped", 32'h0, rd)
    bus(1, 5'h00, 32'h9);
    bus(0, 5'h0c, 0);
    `CHK("refused", 1'b1, rd[1])
    a = {3'h1, 16'($urandom)};
    d = 8'($urandom);
    op(FSAS_OP_PROGRAM, a, d);
    `CHK("err clr", 1'b0, rd[1])
    op(FSAS_OP_POLL, a, 0);
    `CHK("pgm poll", ~d[7], rd[5])
    `CHK("pgm tog", 1'b1, rd[2])
    `CHK("pgm rdy", 1'b0, rd[7])
    wait_ready();
    op(FSAS_OP_POLL, a, 0);
    `CHK("done poll", d[7], rd[5])
    `CHK("done tog", 1'b0, rd[2])
    rdb(a);
    `CHK("pgm data", d, rd[7:0])
    adr_q = '{19'h0, 19'h4, 19'h8, 19'hc, 19'h1, {P_PROT, 16'h2}, {3'h1, 16'h2}};
    exp_q = '{P_MAKER, P_MAKER, P_MAKER, P_MAKER, P_DEV, 8'h01, 8'h00};
    op(FSAS_OP_AUTOSEL, 0, 0);
    foreach (adr_q[i]) begin
      rdb(adr_q[i]);
      `CHK("ident", exp_q[i], rd[7:0])
    end
    op(FSAS_OP_RESET, 0, 0);
    rdb(a);
    `CHK("array", d, rd[7:0])
    op(FSAS_OP_AUTOSEL, 0, 0);
    op(FSAS_OP_WRITE, 19'($urandom), 8'hf0);
    rdb(a);
    `CHK("raw exit", d, rd[7:0])
    op(FSAS_OP_ERASE, a, 0);
    op(FSAS_OP_POLL, a, 0);
    `CHK("win timer", 1'b0, rd[6])
    `CHK("win poll", 1'b0, rd[5])
    `CHK("win tog2", 1'b1, rd[3])
    repeat (300) @(posedge i_clk);
    op(FSAS_OP_POLL, a, 0);
    `CHK("ers timer", 1'b1, rd[6])
    `CHK("ers rdy", 1'b0, rd[7])
    op(FSAS_OP_SUSPEND, 19'h7ffff, 0);
    wait_ready();
    op(FSAS_OP_POLL, a, 0);
    `CHK("sus poll", 1'b1, rd[5])
    `CHK("sus tog1", 1'b0, rd[2])
    `CHK("sus tog2", 1'b1, rd[3])
    c = {3'h2, 16'($urandom)};
    e = 8'($urandom);
    op(FSAS_OP_PROGRAM, c, e);
    op(FSAS_OP_POLL, c, 0);
    `CHK("sp tog1", 1'b1, rd[2])
    `CHK("sp rdy", 1'b0, rd[7])
    wait_ready();
    rdb(c);
    `CHK("sp data", e, rd[7:0])
    op(FSAS_OP_AUTOSEL, 0, 0);
    rdb({a[18:8], 8'h01});
    `CHK("sus ident", P_DEV, rd[7:0])
    op(FSAS_OP_RESET, 0, 0);
    op(FSAS_OP_RESUME, 0, 0);
    op(FSAS_OP_RESUME, 0, 0);
    op(FSAS_OP_POLL, a, 0);
    `CHK("res poll", 1'b0, rd[5])
    wait_ready();
    rdb(a);
    `CHK("erased", 8'hff, rd[7:0])
    tally_and_finish();
  end
endmodule
